// ---- hdl/rco_pkg.sv ----
// Package for the reference clock output block: register map, fields, reset values.
`default_nettype none
package rco_pkg;
	localparam int unsigned ADDR_W       = 10;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned SRC_COUNT    = 12;
	localparam int unsigned SRC_W        = 4;
	localparam int unsigned DIV_W        = 3;
	localparam int unsigned DUTY_W       = 2;
	localparam int unsigned PHASE_W      = 8;
	localparam int unsigned THR_W        = 9;

	localparam logic [ADDR_W-1:0] CONTROL_ADDR = 10'h039;
	localparam logic [ADDR_W-1:0] SOURCE_ADDR  = 10'h03A;

	localparam logic [SRC_W-1:0]  SRC_SYS_OSC  = 4'h0;
	localparam logic [SRC_W-1:0]  SRC_LAST     = 4'hB;
	localparam logic [SRC_W-1:0]  SOURCE_RESET = 4'h0;

	localparam logic [DIV_W-1:0]  DIV_BYPASS   = 3'h0;
	localparam logic [DIV_W-1:0]  DIV_RESET    = 3'h0;
	localparam logic [DUTY_W-1:0] DUTY_OFF     = 2'h0;
	localparam logic [DUTY_W-1:0] DUTY_RESET   = 2'h2;
	localparam logic [DIV_W-1:0]  DIV_ONE      = 3'h1;
	localparam logic [PHASE_W-1:0] PHASE_ZERO  = 8'h00;
	localparam logic [PHASE_W-1:0] PHASE_ONE   = 8'h01;
	localparam logic [THR_W-1:0]  THR_ONE      = 9'h001;
	// Writable control bits: enable, duty and divider; bits 6:5 stay zero
	localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'h9F;

	// Control register layout: enable at bit 7, duty at 4:3, divider at 2:0
	typedef struct packed {
		logic              en;
		logic [1:0]        unused;
		logic [DUTY_W-1:0] duty_sel;
		logic [DIV_W-1:0]  div;
	} rco_ctrl_type;

	localparam rco_ctrl_type CTRL_RESET = '{en: 1'b0, unused: 2'b00,
		duty_sel: DUTY_RESET, div: DIV_RESET};

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} rco_bus_type;

	typedef enum logic [1:0] {
		RCO_IDLE  = 2'b00,
		RCO_ARMED = 2'b01,
		RCO_RUN   = 2'b11
	} rco_state_type;
endpackage
`default_nettype wire

// ---- hdl/rco_refclk.sv ----
// Reference clock output generator with its register port.
`default_nettype none
module rco_refclk
	import rco_pkg::*;
#(
	parameter int unsigned SOURCES = rco_pkg::SRC_COUNT
)
(
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire rco_pkg::rco_bus_type     bus,
	output var  logic [rco_pkg::DATA_W-1:0] rdata,
	input  wire logic [SOURCES-1:0]       src_in,
	input  wire logic                     sleep,
	output var  logic                     ref_clock_out,
	output var  logic                     ref_clock_int
);
	import rco_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	rco_ctrl_type      ctrl;
	logic [SRC_W-1:0]  source_sel;
	rco_state_type     state;
	rco_state_type     next_state;
	logic              src_prev;
	logic [PHASE_W-1:0] phase;
	logic [PHASE_W-1:0] next_phase;
	logic              next_out;
	logic [DATA_W-1:0] next_rdata;

	// Half-cycles of the source in one divided period, minus one
	function automatic logic [PHASE_W-1:0] period_last(input logic [DIV_W-1:0] d);
		logic [THR_W-1:0] halves;
		halves = THR_ONE << d;
		halves = halves << 1;
		period_last = PHASE_W'(halves - THR_ONE);
	endfunction

	// Half-cycles spent high: duty quarters of the period
	function automatic logic [THR_W-1:0] high_halves(input logic [DIV_W-1:0] d,
			input logic [DUTY_W-1:0] q);
		logic [THR_W-1:0] base;
		base = THR_W'(q);
		high_halves = base << (d - DIV_ONE);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register port decode

	wire hit_ctrl   = bus.addr == CONTROL_ADDR;
	wire hit_source = bus.addr == SOURCE_ADDR;
	wire wr_ctrl    = bus.wr & hit_ctrl;
	wire wr_source  = bus.wr & hit_source;

	// Unmapped addresses read as zero
	assign next_rdata = !bus.rd ? '0 :
		hit_ctrl ? DATA_W'(ctrl) :
		hit_source ? DATA_W'(source_sel) : '0;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl       <= CTRL_RESET;
			source_sel <= SOURCE_RESET;
			rdata      <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= rco_ctrl_type'(bus.wdata & CTRL_WR_MASK);
			if (wr_source)
				source_sel <= bus.wdata[SRC_W-1:0];
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source selection and edge detection

	// Reserved codes give a source that never moves
	wire src_valid = (source_sel <= SRC_LAST) && (32'(source_sel) < SOURCES);
	wire src_now   = src_valid ? src_in[source_sel] : 1'b0;
	wire src_rise  = src_now & ~src_prev;
	wire src_turn  = src_now ^ src_prev;

	// The system oscillator is gone in sleep; other sources keep running
	wire halted    = sleep && (source_sel == SRC_SYS_OSC);

	wire bypass    = ctrl.div == DIV_BYPASS;
	wire [PHASE_W-1:0] last_phase = period_last(ctrl.div);
	wire [THR_W-1:0]   threshold  = high_halves(ctrl.div, ctrl.duty_sel);

	////////////////////////////////////////////////////////////////////////////////
	// Generator sequencing

	always_comb
	begin
		next_state = state;
		next_phase = phase;
		case (state)
			RCO_IDLE:
			begin
				if (ctrl.en)
					next_state = RCO_ARMED;
			end
			RCO_ARMED:
			begin
				// Wait for a rising edge so the first pulse is whole
				if (src_rise && !halted)
				begin
					next_state = RCO_RUN;
					next_phase = PHASE_ZERO;
				end
			end
			RCO_RUN:
			begin
				if (src_turn && !halted)
					next_phase = (phase >= last_phase) ? PHASE_ZERO : phase + PHASE_ONE;
			end
			default:
				next_state = RCO_IDLE;
		endcase
		if (!ctrl.en)
		begin
			next_state = RCO_IDLE;
			next_phase = PHASE_ZERO;
		end
	end

	// Settings changed mid-run take effect at once and may glitch the output
	assign next_out = (next_state == RCO_RUN) && !halted &&
		(bypass ? (ctrl.duty_sel != DUTY_OFF) && src_now
		        : (THR_W'(next_phase) < threshold));

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state         <= RCO_IDLE;
			phase         <= PHASE_ZERO;
			src_prev      <= 1'b0;
			ref_clock_out <= 1'b0;
			ref_clock_int <= 1'b0;
		end
		else
		begin
			state         <= next_state;
			phase         <= next_phase;
			src_prev      <= src_now;
			ref_clock_out <= next_out;
			ref_clock_int <= next_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	stop_at_once_a: assert property (@(posedge clk) disable iff (!arst_n)
		!ctrl.en |=> !ref_clock_out)
		else $error("output high after disable");

	clean_start_a: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(ref_clock_out) && $past(state) != RCO_RUN |-> $past(src_rise))
		else $error("output started away from a source rising edge");

	both_outputs_a: assert property (@(posedge clk) disable iff (!arst_n)
		ref_clock_out == ref_clock_int)
		else $error("pin and internal clock differ");

	zero_duty_low_a: assert property (@(posedge clk) disable iff (!arst_n)
		ctrl.duty_sel == DUTY_OFF ##1 ctrl.duty_sel == DUTY_OFF |-> !ref_clock_out)
		else $error("output high with zero duty");

	sleep_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
		halted |=> !ref_clock_out)
		else $error("output running in sleep on system oscillator");

	phase_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN && $stable(ctrl) |-> phase <= last_phase)
		else $error("phase beyond divided period");

	bypass_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN && bypass && ctrl.duty_sel != DUTY_OFF && ctrl.en && !halted
		|=> ref_clock_out == $past(src_now) || !ctrl.en || $past(sleep))
		else $error("undivided output does not follow source");

	source_write_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr_source |=> source_sel == $past(bus.wdata[SRC_W-1:0]))
		else $error("source select not written");

	quarter_high_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN && !bypass && phase == PHASE_ZERO && !halted
		&& ctrl.duty_sel != DUTY_OFF && $stable(state) |-> ref_clock_out)
		else $error("divided period does not open high");

	////////////////////////////////////////////////////////////////////////////////
	// Register port checks

	ctrl_write_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr_ctrl |=> ctrl == rco_ctrl_type'($past(bus.wdata) & CTRL_WR_MASK))
		else $error("control register not written");

	ctrl_read_a: assert property (@(posedge clk) disable iff (!arst_n)
		bus.rd && hit_ctrl |=> rdata == DATA_W'($past(ctrl)))
		else $error("control read data wrong");

	source_read_a: assert property (@(posedge clk) disable iff (!arst_n)
		bus.rd && hit_source |=> rdata == DATA_W'($past(source_sel)))
		else $error("source read data wrong");

	unmapped_read_a: assert property (@(posedge clk) disable iff (!arst_n)
		bus.rd && !hit_ctrl && !hit_source |=> rdata == '0)
		else $error("unmapped read not zero");

	read_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
		!bus.rd |=> rdata == '0)
		else $error("read data without a read");

	unused_bits_a: assert property (@(posedge clk) disable iff (!arst_n)
		ctrl.unused == '0)
		else $error("unused control bits set");

	////////////////////////////////////////////////////////////////////////////////
	// Sequencing checks

	legal_state_a: assert property (@(posedge clk) disable iff (!arst_n)
		state inside {RCO_IDLE, RCO_ARMED, RCO_RUN})
		else $error("generator state illegal");

	arm_on_enable_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_IDLE && ctrl.en |=> state == RCO_ARMED)
		else $error("enable did not arm the generator");

	idle_on_disable_a: assert property (@(posedge clk) disable iff (!arst_n)
		!ctrl.en |=> state == RCO_IDLE)
		else $error("disable did not idle the generator");

	run_needs_en_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN |-> $past(ctrl.en))
		else $error("running without enable");

	idle_phase_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_IDLE |-> phase == PHASE_ZERO)
		else $error("phase not cleared while idle");

	quiet_unless_run_a: assert property (@(posedge clk) disable iff (!arst_n)
		state != RCO_RUN |-> !ref_clock_out)
		else $error("output high before the generator runs");

	armed_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_ARMED && !src_rise && ctrl.en |=> state == RCO_ARMED)
		else $error("started without a source rising edge");

	start_phase_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_ARMED && src_rise && !halted && ctrl.en
		|=> state == RCO_RUN && phase == PHASE_ZERO)
		else $error("start not at phase zero");

	////////////////////////////////////////////////////////////////////////////////
	// Source, divider and duty checks

	reserved_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
		!src_valid |-> !src_now)
		else $error("reserved source code moves");

	divided_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN && !bypass && phase >= last_phase && src_turn && !halted
		&& ctrl.en |=> phase == PHASE_ZERO)
		else $error("divided period did not wrap");

	high_end_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN && !bypass && THR_W'(phase) >= threshold
		&& $stable(ctrl) && $stable(state) |-> !ref_clock_out)
		else $error("output high past its quarters");

	bypass_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
		bypass && ctrl.duty_sel == DUTY_OFF |=> !ref_clock_out)
		else $error("undivided zero duty not low");

	////////////////////////////////////////////////////////////////////////////////
	// Sleep checks

	sleep_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN && halted && ctrl.en |=> phase == $past(phase))
		else $error("phase moved while oscillator halted");

	sleep_hold_arm_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_ARMED && halted && ctrl.en |=> state == RCO_ARMED)
		else $error("started while oscillator halted");

	sleep_keeps_a: assert property (@(posedge clk) disable iff (!arst_n)
		state == RCO_RUN && sleep && !halted && ctrl.en |=> state == RCO_RUN)
		else $error("other source stopped in sleep");
endmodule
`default_nettype wire

// ---- verification/rco_src_model.sv ----
// Clock source model: twelve sources of differing rates, free-running except the system oscillator, which halts in sleep.
`default_nettype none
module rco_src_model
	import rco_pkg::*;
#(
	parameter int unsigned SOURCES = SRC_COUNT
)
(
	input  wire logic               clk,
	input  wire logic               sleep,
	output var  logic [SOURCES-1:0] src
);
	timeunit 1ns;
	timeprecision 1ps;
	// Source n toggles every 1 + n mod 3 clocks, so every rate is a whole number of cycles
	logic [1:0] cnt [SOURCES];
	initial
	begin
		src = '0;
		foreach (cnt[i]) cnt[i] = 2'h0;
	end
	always @(posedge clk)
	begin
		foreach (cnt[i])
		begin
			// The system oscillator halts in sleep
			if (!(sleep && i == 0))
			begin
				cnt[i] <= (cnt[i] == 2'(i % 3)) ? 2'h0 : cnt[i] + 2'h1;
				if (cnt[i] == 2'(i % 3))
					src[i] <= ~src[i];
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the reference clock generator.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rco_pkg::*;
	logic                 clk = 1'h0;
	logic                 arst_n = 1'h0;
	rco_bus_type          bus = '0;
	logic [DATA_W-1:0]    rdata;
	logic [SRC_COUNT-1:0] src;
	logic                 sleep = 1'h0;
	logic                 out;
	logic                 out_int;
	int                   num_errors = 0;
	int                   checked = 0;
	int                   seed = 76534;
	always #4 clk = ~clk;
	rco_src_model i_rco_src_model (.clk(clk), .sleep(sleep), .src(src));
	rco_refclk i_rco_refclk (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
		.src_in(src), .sleep(sleep), .ref_clock_out(out), .ref_clock_int(out_int));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	// Output period in clocks: source half period times 2^(div+1) halves
	function automatic int period(input int s, input int dv);
		return (1 + s % 3) * (2 << dv);
	endfunction
	function automatic int exp_high(input int s, input int dv, input int dt, input logic slp);
		if (s > 11 || (slp && s == 0) || dt == 0)
			return 0;
		if (dv == 0)
			return 1 + s % 3;
		return dt * (1 + s % 3) * (1 << dv) / 2;
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] v;
		int s, dv, dt, hi, hj;
		logic slp;
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		rd(CONTROL_ADDR, d);
		chk("ctrl reset", 16'h0010, {8'h00, d});
		rd(SOURCE_ADDR, d);
		chk("src reset", 16'h0000, {8'h00, d});
		for (int k = 0; k < 4; k++)
		begin
			v = 8'($random(seed));
			wr(CONTROL_ADDR, v & 8'h7F);
			wr(SOURCE_ADDR, v);
			wr(10'h03B, ~v);
			rd(CONTROL_ADDR, d);
			chk("ctrl", {8'h00, v & 8'h1F}, {8'h00, d});
			rd(SOURCE_ADDR, d);
			chk("src", {8'h00, v & 8'h0F}, {8'h00, d});
			rd(10'h03B, d);
			chk("unmapped", 16'h0000, {8'h00, d});
		end
		for (int k = 0; k < 24; k++)
		begin
			dv = k % 8;
			dt = (k + k / 8) % 4;
			s = {$random(seed)} % 16;
			slp = 1'($random(seed));
			if (k < 4)
			begin
				s = (k < 2) ? 0 : 9 + k;
				slp = (k == 1);
			end
			sleep <= slp;
			wr(CONTROL_ADDR, {1'h0, 2'h0, 2'(dt), 3'(dv)});
			wr(SOURCE_ADDR, 8'(s));
			wr(CONTROL_ADDR, {1'h1, 2'h0, 2'(dt), 3'(dv)});
			hi = 0;
			hj = 0;
			repeat (period(s, dv) + 8) @(posedge clk);
			repeat (period(s, dv))
			begin
				@(posedge clk);
				#1 hi += out;
				hj += out_int;
			end
			chk("high time", 16'(exp_high(s, dv, dt, slp)), 16'(hi));
			chk("internal high", 16'(exp_high(s, dv, dt, slp)), 16'(hj));
			wr(CONTROL_ADDR, {1'h0, 2'h0, 2'(dt), 3'(dv)});
			@(posedge clk);
			#1 chk("stopped", 16'h0000, {15'h0000, out});
		end
		results();
	end
endmodule
`default_nettype wire
